// ==== rtl/timer16_compare_capture_irq.sv ====
`timescale 1ns/100ps
module timer16_compare_capture_irq
   import timer16_pkg::*;
#(
   parameter int FILTER_LEN = FILTER_SAMPLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic captureInputPin,
   input wire logic comparatorOut,
   input wire logic [3:0] vectorAck,
   output logic [3:0] irqReq,
   output logic irq,
   output logic compareMatchA,
   output logic compareMatchB
);

   apbState_e apbStateFF;
   logic preadyFF, pslverrFF;
   logic [31:0] prdataFF;
   logic [7:0] tempFF, maskFF, flagsFF;
   logic [15:0] counterFF, cmpAFF, cmpBFF, capFF;
   waveMode_e modeFF;
   clkSel_e csFF;
   logic edgeRiseFF, filterOnFF, fromComparatorFF;
   logic downFF, blockFF;
   logic [9:0] preFF;
   logic sampleFF, levelFF, prevLevelFF;
   logic [FILTER_LEN-1:0] histFF;
   logic [3:0] irqReqFF;
   logic irqFF, matchAOutFF, matchBOutFF;

   logic mapped, wrStrobe, rdStrobe, cpuCntWr, tick;
   logic [15:0] topVal;
   logic hitA, hitB, ovfSet, capTopSet, capEvt, forceA, forceB, nonPwm;
   logic [7:0] flagSet, flagClr;

   function automatic logic isMapped(input logic [11:0] a);
      case (a)
         OFS_CNT_LO, OFS_CNT_HI, OFS_CMPA_LO, OFS_CMPA_HI, OFS_CMPB_LO, OFS_CMPB_HI,
         OFS_CAP_LO, OFS_CAP_HI, OFS_MASK, OFS_FLAGS, OFS_CTRL: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // write takes effect only at the completing edge; read data is fetched one edge earlier
   assign mapped = isMapped(paddr);
   assign wrStrobe = (apbStateFF == APB_DONE) && psel && penable && pwrite && mapped;
   assign rdStrobe = (apbStateFF == APB_IDLE) && psel && penable && !pwrite && mapped;
   assign cpuCntWr = wrStrobe && (paddr == OFS_CNT_LO);

   always_ff @(posedge clk) begin
      if (rst) begin
         apbStateFF <= APB_IDLE;
         preadyFF <= 1'b0;
         pslverrFF <= 1'b0;
      end else begin
         case (apbStateFF)
            APB_IDLE: begin
               if (psel && penable) begin
                  apbStateFF <= APB_DONE;
                  preadyFF <= 1'b1;
                  pslverrFF <= !mapped;
               end
            end
            APB_DONE: begin
               apbStateFF <= APB_IDLE;
               preadyFF <= 1'b0;
               pslverrFF <= 1'b0;
            end
            default: begin
               apbStateFF <= APB_IDLE;
               preadyFF <= 1'b0;
               pslverrFF <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prdataFF <= 32'h00000000;
      end else if (psel && penable && !pwrite && (apbStateFF == APB_IDLE)) begin
         case (paddr)
            OFS_CNT_LO: prdataFF <= {24'h000000, counterFF[7:0]};
            OFS_CNT_HI: prdataFF <= {24'h000000, tempFF};
            OFS_CMPA_LO: prdataFF <= {24'h000000, cmpAFF[7:0]};
            OFS_CMPA_HI: prdataFF <= {24'h000000, cmpAFF[15:8]};
            OFS_CMPB_LO: prdataFF <= {24'h000000, cmpBFF[7:0]};
            OFS_CMPB_HI: prdataFF <= {24'h000000, cmpBFF[15:8]};
            OFS_CAP_LO: prdataFF <= {24'h000000, capFF[7:0]};
            OFS_CAP_HI: prdataFF <= {24'h000000, tempFF};
            OFS_MASK: prdataFF <= {24'h000000, maskFF};
            OFS_FLAGS: prdataFF <= {24'h000000, flagsFF};
            // force strobes always read back as zero
            OFS_CTRL: prdataFF <= {20'h00000, 2'b00, fromComparatorFF, filterOnFF,
                                   edgeRiseFF, csFF,
                                   modeFF};
            default: prdataFF <= 32'h00000000;
         endcase
      end
   end

   // shared high-byte latch for every 16-bit register
   always_ff @(posedge clk) begin
      if (rst) begin
         tempFF <= TEMP_RST;
      end else if (wrStrobe && ((paddr == OFS_CNT_HI) || (paddr == OFS_CMPA_HI) ||
                               (paddr == OFS_CMPB_HI) || (paddr == OFS_CAP_HI))) begin
         tempFF <= pwdata[7:0];
      end else if (rdStrobe && (paddr == OFS_CNT_LO)) begin
         tempFF <= counterFF[15:8];
      end else if (rdStrobe && (paddr == OFS_CAP_LO)) begin
         tempFF <= capFF[15:8];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmpAFF <= VALUE16_RST;
         cmpBFF <= VALUE16_RST;
      end else if (wrStrobe && (paddr == OFS_CMPA_LO)) begin
         cmpAFF <= {tempFF, pwdata[7:0]};
      end else if (wrStrobe && (paddr == OFS_CMPB_LO)) begin
         cmpBFF <= {tempFF, pwdata[7:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         maskFF <= MASK_RST;
      end else if (wrStrobe && (paddr == OFS_MASK)) begin
         maskFF <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         modeFF <= MODE_NORMAL;
         csFF <= CS_STOP;
         edgeRiseFF <= 1'b0;
         filterOnFF <= 1'b0;
         fromComparatorFF <= 1'b0;
      end else if (wrStrobe && (paddr == OFS_CTRL)) begin
         modeFF <= waveMode_e'(pwdata[CTRL_MODE_LSB +: 4]);
         csFF <= clkSel_e'(pwdata[CTRL_CS_LSB +: 3]);
         edgeRiseFF <= pwdata[CTRL_EDGE_BIT];
         filterOnFF <= pwdata[CTRL_FILT_BIT];
         fromComparatorFF <= pwdata[CTRL_ACO_BIT];
      end
   end

   // timer tick from the prescaler; external clock selections have no pin here and stop
   always_ff @(posedge clk) begin
      if (rst) begin
         preFF <= 10'h000;
      end else if (csFF == CS_STOP) begin
         preFF <= 10'h000;
      end else begin
         preFF <= preFF + 10'h001;
      end
   end

   always_comb begin
      case (csFF)
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = (preFF & DIV8_MASK) == DIV8_MASK;
         CS_DIV64: tick = (preFF & DIV64_MASK) == DIV64_MASK;
         CS_DIV256: tick = (preFF & DIV256_MASK) == DIV256_MASK;
         CS_DIV1024: tick = (preFF & DIV1024_MASK) == DIV1024_MASK;
         default: tick = 1'b0;
      endcase
   end

   assign topVal = topOf(modeFF, cmpAFF, capFF);

   // cpu write wins over any count or clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         counterFF <= VALUE16_RST;
         downFF <= 1'b0;
      end else if (cpuCntWr) begin
         counterFF <= {tempFF, pwdata[7:0]};
      end else if (tick) begin
         if (isDualSlope(modeFF)) begin
            if (!downFF && (counterFF == topVal)) begin
               downFF <= 1'b1;
               counterFF <= counterFF - 16'h0001;
            end else if (downFF && (counterFF == BOTTOM_VALUE)) begin
               downFF <= 1'b0;
               counterFF <= counterFF + 16'h0001;
            end else begin
               counterFF <= downFF ? counterFF - 16'h0001 : counterFF + 16'h0001;
            end
         end else begin
            downFF <= 1'b0;
            counterFF <= (counterFF == topVal) ? BOTTOM_VALUE : counterFF + 16'h0001;
         end
      end
   end

   // a counter write shields the written value from matching on the next tick
   always_ff @(posedge clk) begin
      if (rst) begin
         blockFF <= 1'b0;
      end else if (cpuCntWr) begin
         blockFF <= 1'b1;
      end else if (tick) begin
         blockFF <= 1'b0;
      end
   end

   assign hitA = tick && !blockFF && (counterFF == cmpAFF);
   assign hitB = tick && !blockFF && (counterFF == cmpBFF);

   always_comb begin
      if (isDualSlope(modeFF)) begin
         ovfSet = tick && downFF && (counterFF == BOTTOM_VALUE);
      end else if (isFastPwm(modeFF)) begin
         ovfSet = tick && (counterFF == topVal);
      end else begin
         ovfSet = tick && (counterFF == MAX_VALUE);
      end
   end

   assign capTopSet = capIsTop(modeFF) && tick && !downFF && (counterFF == topVal);

   // capture input: one sample stage, optional agreement filter, then edge detect
   always_ff @(posedge clk) begin
      if (rst) begin
         sampleFF <= 1'b0;
         histFF <= '0;
         levelFF <= 1'b0;
         prevLevelFF <= 1'b0;
      end else begin
         sampleFF <= fromComparatorFF ? comparatorOut : captureInputPin;
         histFF <= {histFF[FILTER_LEN-2:0], sampleFF};
         if (!filterOnFF) begin
            levelFF <= sampleFF;
         end else if (&histFF || ~|histFF) begin
            levelFF <= histFF[0];
         end
         prevLevelFF <= levelFF;
      end
   end

   // capture pin is cut off while the capture register sets the top
   assign capEvt = !capIsTop(modeFF) && (levelFF != prevLevelFF) &&
                   (levelFF == edgeRiseFF);

   always_ff @(posedge clk) begin
      if (rst) begin
         capFF <= VALUE16_RST;
      end else if (capEvt) begin
         capFF <= counterFF;
      end else if (wrStrobe && (paddr == OFS_CAP_LO)) begin
         capFF <= {tempFF, pwdata[7:0]};
      end
   end

   always_comb begin
      flagSet = 8'h00;
      flagSet[FLAG_CAP] = capEvt || capTopSet;
      flagSet[FLAG_CMPA] = hitA;
      flagSet[FLAG_CMPB] = hitB;
      flagSet[FLAG_OVF] = ovfSet;
      flagClr = (wrStrobe && (paddr == OFS_FLAGS)) ? pwdata[7:0] : 8'h00;
      flagClr[FLAG_CAP] = flagClr[FLAG_CAP] | vectorAck[3];
      flagClr[FLAG_CMPA] = flagClr[FLAG_CMPA] | vectorAck[2];
      flagClr[FLAG_CMPB] = flagClr[FLAG_CMPB] | vectorAck[1];
      flagClr[FLAG_OVF] = flagClr[FLAG_OVF] | vectorAck[0];
   end

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         flagsFF <= FLAGS_RST;
      end else begin
         flagsFF <= ((flagsFF & ~flagClr) | flagSet) & FLAGS_USED;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqReqFF <= 4'h0;
         irqFF <= 1'b0;
      end else begin
         irqReqFF[3] <= flagsFF[FLAG_CAP] & maskFF[FLAG_CAP];
         irqReqFF[2] <= flagsFF[FLAG_CMPA] & maskFF[FLAG_CMPA];
         irqReqFF[1] <= flagsFF[FLAG_CMPB] & maskFF[FLAG_CMPB];
         irqReqFF[0] <= flagsFF[FLAG_OVF] & maskFF[FLAG_OVF];
         irqFF <= |(flagsFF & maskFF & FLAGS_USED);
      end
   end

   // force strobes only act in the non-pwm modes and only reach the match outputs
   assign nonPwm = (modeFF == MODE_NORMAL) || (modeFF == MODE_CTC_CMPA) ||
                   (modeFF == MODE_CTC_CAP);
   assign forceA = wrStrobe && (paddr == OFS_CTRL) && pwdata[CTRL_FOCA_BIT] && nonPwm;
   assign forceB = wrStrobe && (paddr == OFS_CTRL) && pwdata[CTRL_FOCB_BIT] && nonPwm;

   always_ff @(posedge clk) begin
      if (rst) begin
         matchAOutFF <= 1'b0;
         matchBOutFF <= 1'b0;
      end else begin
         matchAOutFF <= hitA || forceA;
         matchBOutFF <= hitB || forceB;
      end
   end

   assign pready = preadyFF;
   assign prdata = prdataFF;
   assign pslverr = pslverrFF;
   assign irqReq = irqReqFF;
   assign irq = irqFF;
   assign compareMatchA = matchAOutFF;
   assign compareMatchB = matchBOutFF;

endmodule // timer16_compare_capture_irq

// ==== rtl/timer16_pkg.sv ====
package timer16_pkg;

   // register byte addresses, one aligned word each, data in bits [7:0] or [11:0]
   localparam logic [11:0] OFS_CNT_LO = 12'h000;
   localparam logic [11:0] OFS_CNT_HI = 12'h004;
   localparam logic [11:0] OFS_CMPA_LO = 12'h008;
   localparam logic [11:0] OFS_CMPA_HI = 12'h00C;
   localparam logic [11:0] OFS_CMPB_LO = 12'h010;
   localparam logic [11:0] OFS_CMPB_HI = 12'h014;
   localparam logic [11:0] OFS_CAP_LO = 12'h018;
   localparam logic [11:0] OFS_CAP_HI = 12'h01C;
   localparam logic [11:0] OFS_MASK = 12'h020;
   localparam logic [11:0] OFS_FLAGS = 12'h024;
   localparam logic [11:0] OFS_CTRL = 12'h028;

   // control word fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_CS_LSB = 4;
   localparam int CTRL_EDGE_BIT = 7;
   localparam int CTRL_FILT_BIT = 8;
   localparam int CTRL_ACO_BIT = 9;
   localparam int CTRL_FOCA_BIT = 10;
   localparam int CTRL_FOCB_BIT = 11;

   // flag and mask bit positions
   localparam int FLAG_CAP = 5;
   localparam int FLAG_CMPA = 4;
   localparam int FLAG_CMPB = 3;
   localparam int FLAG_OVF = 2;
   localparam logic [7:0] FLAGS_USED = 8'h3C;

   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] TEMP_RST = 8'h00;
   localparam logic [15:0] VALUE16_RST = 16'h0000;
   localparam logic [2:0] CS_RST = 3'h0;

   localparam logic [15:0] MAX_VALUE = 16'hFFFF;
   localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;

   // prescaler taps: count mask = divisor - 1
   localparam logic [9:0] DIV8_MASK = 10'h007;
   localparam logic [9:0] DIV64_MASK = 10'h03F;
   localparam logic [9:0] DIV256_MASK = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;

   localparam int FILTER_SAMPLES = 4;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h0, MODE_PC8 = 4'h1, MODE_PC9 = 4'h2, MODE_PC10 = 4'h3,
      MODE_CTC_CMPA = 4'h4, MODE_FAST8 = 4'h5, MODE_FAST9 = 4'h6, MODE_FAST10 = 4'h7,
      MODE_PFC_CAP = 4'h8, MODE_PFC_CMPA = 4'h9, MODE_PC_CAP = 4'hA, MODE_PC_CMPA = 4'hB,
      MODE_CTC_CAP = 4'hC, MODE_RESERVED = 4'hD, MODE_FAST_CAP = 4'hE, MODE_FAST_CMPA = 4'hF
   } waveMode_e;

   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } clkSel_e;

   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_DONE = 2'b01
   } apbState_e;

   function automatic logic [15:0] topOf(input waveMode_e m, input logic [15:0] cmpA,
                                         input logic [15:0] cap);
      case (m)
         MODE_PC8, MODE_FAST8: topOf = TOP_8BIT;
         MODE_PC9, MODE_FAST9: topOf = TOP_9BIT;
         MODE_PC10, MODE_FAST10: topOf = TOP_10BIT;
         MODE_CTC_CMPA, MODE_PFC_CMPA, MODE_PC_CMPA, MODE_FAST_CMPA: topOf = cmpA;
         MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP: topOf = cap;
         default: topOf = MAX_VALUE;
      endcase
   endfunction

   function automatic logic capIsTop(input waveMode_e m);
      capIsTop = (m == MODE_PFC_CAP) || (m == MODE_PC_CAP) || (m == MODE_CTC_CAP) ||
                 (m == MODE_FAST_CAP);
   endfunction

   function automatic logic isDualSlope(input waveMode_e m);
      isDualSlope = (m == MODE_PC8) || (m == MODE_PC9) || (m == MODE_PC10) ||
                    (m == MODE_PFC_CAP) || (m == MODE_PFC_CMPA) || (m == MODE_PC_CAP) ||
                    (m == MODE_PC_CMPA);
   endfunction

   function automatic logic isFastPwm(input waveMode_e m);
      isFastPwm = (m == MODE_FAST8) || (m == MODE_FAST9) || (m == MODE_FAST10) ||
                  (m == MODE_FAST_CAP) || (m == MODE_FAST_CMPA);
   endfunction

endpackage

// ==== tb/timer16_irq_sva.sv ====
`timescale 1ns/100ps
module timer16_irq_sva #(
   parameter int FILTER_LEN = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] vectorAck,
   input wire logic [3:0] irqReq,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence setupPhase;
      psel && !penable;
   endsequence
   sequence accessStart;
      psel && penable && !pready;
   endsequence
   a_access_answer: assert property (setupPhase ##1 accessStart |=> pready)
      else $error("pready not one cycle after access start");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_irq_or_req: assert property (irq == (|irqReq))
      else $error("irq differs from request OR");
   // requests lag the flags by one cycle, so the clear shows two edges on
   a_ack_cap_clear: assert property (vectorAck[3] |=> ##1 !irqReq[3])
      else $error("capture request survives ack");
   a_ack_cmpa_clear: assert property (vectorAck[2] |=> ##1 !irqReq[2])
      else $error("compare A request survives ack");
   a_ack_cmpb_clear: assert property (vectorAck[1] |=> ##1 !irqReq[1])
      else $error("compare B request survives ack");
   a_ack_ovf_clear: assert property (vectorAck[0] |=> ##1 !irqReq[0])
      else $error("overflow request survives ack");
endmodule // timer16_irq_sva

bind timer16_compare_capture_irq timer16_irq_sva #(.FILTER_LEN(FILTER_LEN)) u_timer16_irq_sva (
   .clk(clk),
   .rst(rst),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .vectorAck(vectorAck),
   .irqReq(irqReq),
   .irq(irq)
);

// ==== tb/cpu_vector_model.sv ====
`timescale 1ns/100ps
module cpu_vector_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] irqReq,
   input wire logic globalEnable,
   input wire logic [3:0] ackDelay,
   output logic [3:0] vectorAck
);
   logic [3:0] waitCnt_ff;
   logic [2:0] holdOff_ff;
   // hold-off covers the two-cycle lag of the request after a clear
   always @(posedge clk) begin
      vectorAck <= 4'h0;
      if (rst) begin
         waitCnt_ff <= 4'h0;
         holdOff_ff <= 3'h0;
      end else if (holdOff_ff != 3'h0) begin
         holdOff_ff <= holdOff_ff - 3'h1;
      end else if (globalEnable && irqReq != 4'h0) begin
         if (waitCnt_ff >= ackDelay) begin
            vectorAck <= irqReq[3] ? 4'h8 : irqReq[2] ? 4'h4 : irqReq[1] ? 4'h2 : 4'h1;
            waitCnt_ff <= 4'h0;
            holdOff_ff <= 3'h4;
         end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
         end
      end
   end
endmodule // cpu_vector_model

// ==== tb/timer16_compare_capture_irq_tb.sv ====
`timescale 1ns/100ps
module timer16_compare_capture_irq_tb;
   import timer16_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rdErr;
   logic captureInputPin, comparatorOut, compareMatchA, compareMatchB, ackEnable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic [3:0] vectorAck, irqReq, ackDelay;
   int nFail, samplesChecked, matchA, matchB;
   timer16_compare_capture_irq u_timer16_compare_capture_irq (.clk(clk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .captureInputPin(captureInputPin),
      .comparatorOut(comparatorOut), .vectorAck(vectorAck), .irqReq(irqReq), .irq(irq),
      .compareMatchA(compareMatchA), .compareMatchB(compareMatchB));
   cpu_vector_model u_cpu_vector_model (.clk(clk), .rst(rst), .irqReq(irqReq),
      .globalEnable(ackEnable), .ackDelay(ackDelay), .vectorAck(vectorAck));
   always #5 clk = ~clk;
   always @(negedge clk) if (compareMatchA === 1'b1) matchA++;
   always @(negedge clk) if (compareMatchB === 1'b1) matchB++;
   task automatic conclude();
      $display("compares=%0d mismatches=%0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bail();
      nFail++;
      conclude();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nFail++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready, read data and error are taken at the edge that samples pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) bail();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apbXfer(1'b1, a, d, rdData, rdErr);
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apbXfer(1'b0, a, 32'h0, rdData, rdErr);
      check(rdData, exp);
   endtask
   // counts edges until the request line reaches the level, bounded
   task automatic countUntil(input int b, input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irqReq[b] !== lvl && n < 64);
      if (irqReq[b] !== lvl) bail();
   endtask
   task automatic scenReset();
      rdChk(OFS_MASK, 32'h0);
      rdChk(OFS_FLAGS, 32'h0);
      apbXfer(1'b0, 12'h030, 32'h0, rdData, rdErr);
      check({31'h0, rdErr}, 32'h1);
      check(rdData, 32'h0);
      wr(OFS_MASK, 32'hC3);
      rdChk(OFS_MASK, 32'hC3);
      check({28'h0, irqReq}, 32'h0);
   endtask
   task automatic scenCompare();
      int n;
      wr(OFS_CMPA_HI, 32'h12);
      rdChk(OFS_CMPA_HI, 32'h0);
      wr(OFS_CMPA_HI, 32'h0);
      wr(OFS_CMPA_LO, 32'h40);
      rdChk(OFS_CMPA_LO, 32'h40);
      wr(OFS_CMPB_HI, 32'h0);
      wr(OFS_CMPB_LO, 32'h38);
      wr(OFS_MASK, 32'h18);
      wr(OFS_CNT_HI, 32'h0);
      wr(OFS_CNT_LO, 32'h40);
      wr(OFS_CTRL, 32'h10);
      repeat (4) @(posedge clk);
      rdChk(OFS_FLAGS, 32'h0);
      check(32'(matchA), 32'h0);
      wr(OFS_CNT_HI, 32'h0);
      wr(OFS_CNT_LO, 32'h30);
      countUntil(1, 1'b1, n);
      check(32'(n), 32'h38 - 32'h30 + 32'h2);
      countUntil(2, 1'b1, n);
      check(32'(n), 32'h40 - 32'h38);
      check({31'h0, irq}, 32'h1);
      wr(OFS_FLAGS, 32'h10);
      rdChk(OFS_FLAGS, 32'h08);
      check(32'(matchA), 32'h1);
      check(32'(matchB), 32'h1);
      ackDelay <= 4'h0;
      ackEnable <= 1'b1;
      countUntil(1, 1'b0, n);
      @(posedge clk);
      ackEnable <= 1'b0;
      rdChk(OFS_FLAGS, 32'h0);
   endtask
   task automatic scenForce();
      wr(OFS_FLAGS, 32'h3C);
      wr(OFS_CTRL, 32'hC10);
      repeat (4) @(posedge clk);
      check(32'(matchA), 32'h2);
      check(32'(matchB), 32'h2);
      rdChk(OFS_FLAGS, 32'h0);
      rdChk(OFS_CTRL, 32'h10);
   endtask
   task automatic scenOverflow();
      int n;
      wr(OFS_MASK, 32'h04);
      wr(OFS_CNT_HI, 32'hFF);
      wr(OFS_CNT_LO, 32'hF0);
      countUntil(0, 1'b1, n);
      check(32'(n), 32'hFFFF - 32'hFFF0 + 32'h2);
      check({31'h0, irq}, 32'h1);
      @(posedge clk);
      ackDelay <= 4'h5;
      ackEnable <= 1'b1;
      countUntil(0, 1'b0, n);
      @(posedge clk);
      ackEnable <= 1'b0;
      apbXfer(1'b0, OFS_FLAGS, 32'h0, rdData, rdErr);
      check(rdData & 32'h4, 32'h0);
   endtask
   task automatic scenCapture();
      logic [15:0] ctrlTab [4];
      logic [15:0] val;
      logic [15:0] expCap;
      // pin rising, comparator source, filtered falling pin, then capture-as-top with pin cut off
      ctrlTab = '{16'h0080, 16'h0280, 16'h0100, 16'h008C};
      expCap = VALUE16_RST;
      wr(OFS_MASK, 32'h20);
      for (int i = 0; i < 4; i++) begin
         val = 16'hA0C0 + 16'(i);
         wr(OFS_CTRL, {16'h0, ctrlTab[i]});
         rdChk(OFS_CTRL, {16'h0, ctrlTab[i]});
         wr(OFS_CNT_HI, {24'h0, val[15:8]});
         wr(OFS_CNT_LO, {24'h0, val[7:0]});
         wr(OFS_FLAGS, 32'h3C);
         if (ctrlTab[i][9])
            comparatorOut <= 1'b1;
         else
            captureInputPin <= 1'b1;
         repeat (12) @(posedge clk);
         comparatorOut <= 1'b0;
         captureInputPin <= 1'b0;
         repeat (12) @(posedge clk);
         if (i < 3)
            expCap = val;
         rdChk(OFS_FLAGS, (i < 3) ? 32'h20 : 32'h0);
         check({28'h0, irqReq}, (i < 3) ? 32'h8 : 32'h0);
         rdChk(OFS_CAP_LO, {24'h0, expCap[7:0]});
         rdChk(OFS_CAP_HI, {24'h0, expCap[15:8]});
      end
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      captureInputPin = 1'b0;
      comparatorOut = 1'b0;
      ackEnable = 1'b0;
      ackDelay = 4'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      scenReset();
      scenCompare();
      scenForce();
      scenOverflow();
      scenCapture();
      conclude();
   end
endmodule // timer16_compare_capture_irq_tb
